// ==== hw/sco_debounce.sv ====
// event input debounce filter for the event counter
// assumes the input is already synchronised to clk
`timescale 1ns/1ps
module sco_debounce (
  input  wire logic clk,
  input  wire logic rst,
  sco_tick_if.dst   tif,
  input  wire logic din,
  output logic      dout,
  output logic      rise
);
  typedef struct packed {
    logic        lvl;
    logic [15:0] cnt;
    logic        rise;
  } sco_db_t;
  sco_db_t st_reg, st_next;
  logic [15:0] lim;
  // ------------------------------------------------------------
  // filter constant select
  // ------------------------------------------------------------
  always_comb begin
    case (tif.filt_sel)
      2'h1:    lim = 16'(sco_pkg::FILT_5_TICKS);
      2'h2:    lim = 16'(sco_pkg::FILT_20_TICKS);
      2'h3:    lim = 16'(sco_pkg::FILT_50_TICKS);
      default: lim = 16'h0000;
    endcase
    st_next = st_reg;
    st_next.rise = 1'b0;
    if (din == st_reg.lvl) begin
      st_next.cnt = 16'h0000;
    end else if (lim == 16'h0000) begin
      st_next.lvl  = din;
      st_next.rise = din;
    end else if (tif.tick) begin
      if (st_reg.cnt + 16'h0001 >= lim) begin
        st_next.lvl  = din;
        st_next.rise = din;
        st_next.cnt  = 16'h0000;
      end else begin
        st_next.cnt = st_reg.cnt + 16'h0001;
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign dout = st_reg.lvl;
  assign rise = st_reg.rise;
endmodule : sco_debounce

// ==== hw/sco_hexfmt.sv ====
// parallel word formatter: maps lines to a word-length field
// assumes word count already limited to 1..8
`timescale 1ns/1ps
module sco_hexfmt (
  input  wire logic [15:0] lines_in,
  input  wire logic [3:0]  wlen,
  output logic [63:0]      rd_word
);
  always_comb begin
    rd_word = {64{1'b1}};
    rd_word[15:0] = lines_in;
    for (int i = 0; i < 64; i++) begin
      if (i >= 8 * int'(wlen)) begin
        rd_word[i] = 1'b0;
      end
    end
  end
endmodule : sco_hexfmt

// ==== hw/sco_setup_cont.sv ====
// setup options and continuous output control
// assumes a serial core that decodes commands and sends strings
`timescale 1ns/1ps
module sco_setup_cont #(
  parameter logic [7:0] WLEN_RST = 8'h02
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        cmd_valid,
  input  wire logic [2:0]  cmd_code,
  input  wire logic [31:0] cmd_setup,
  input  wire logic [4:0]  cmd_digits,
  input  wire logic [63:0] cmd_pdata,
  input  wire logic        cmd_bitop,
  input  wire logic        cmd_bitval,
  input  wire logic [3:0]  cmd_bitidx,
  input  wire logic        resp_done,
  input  wire logic        rx_char,
  input  wire logic        char_time,
  input  wire logic        native_proto,
  input  wire logic [3:0]  cmode_sel,
  input  wire logic        cmode_load,
  input  wire logic        period_load,
  input  wire logic [31:0] period_ticks,
  input  wire logic [15:0] io_pin_in,
  input  wire logic        event_input_pin,
  output logic             echo_req,
  output logic             resp_go,
  output logic             resp_syntax_err,
  output logic             resp_refused,
  output logic [31:0]      setup_rd,
  output logic [63:0]      parallel_rd,
  output logic [15:0]      io_out,
  output logic [3:0]       word_count,
  output logic             cont_send,
  input  wire logic        cont_done,
  output logic             recovery_pin_out,
  output logic             recovery_pin_oe,
  output logic [31:0]      event_count
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  addr;
    logic [7:0]  baud;
    logic [7:0]  comm_options_byte;
    logic [7:0]  filter_wordlength_byte;
    logic [31:0] pend_setup;
    logic        pend_valid;
    logic        unlocked;
    logic [15:0] out_lat;
    logic [3:0]  dly_cnt;
    logic        dly_run;
    logic        go;
    logic        syn_err;
    logic        refused;
    logic [3:0]  cmode;
    logic [31:0] per_ticks;
    logic [31:0] per_cnt;
    logic [15:0] last_io;
    logic        send;
    logic        busy;
    logic [15:0] pulse_cnt;
    logic        pulse_on;
    logic [31:0] ev_cnt;
    logic [6:0]  tick_div;
    logic        tick;
  } sco_st_t;
  sco_st_t st_reg, st_next;
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [15:0] io_s1_reg, io_s2_reg;
  logic        ev_s1_reg, ev_s2_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_s1_reg <= 16'h0000;
      io_s2_reg <= 16'h0000;
      ev_s1_reg <= 1'b0;
      ev_s2_reg <= 1'b0;
    end else begin
      io_s1_reg <= io_pin_in;
      io_s2_reg <= io_s1_reg;
      ev_s1_reg <= event_input_pin;
      ev_s2_reg <= ev_s1_reg;
    end
  end
  // ------------------------------------------------------------
  // debounce and formatting
  // ------------------------------------------------------------
  sco_tick_if tif ();
  logic ev_rise;
  assign tif.tick     = st_reg.tick;
  assign tif.filt_sel = st_reg.filter_wordlength_byte[sco_pkg::FILT_LSB+:2];
  sco_debounce u_db (
    .clk  (clk),
    .rst  (rst),
    .tif  (tif.dst),
    .din  (ev_s2_reg),
    .dout (),
    .rise (ev_rise)
  );
  logic [3:0]  wlen;
  logic [63:0] rd_word;
  assign wlen = st_reg.filter_wordlength_byte[sco_pkg::WLEN_LSB+:4];
  sco_hexfmt u_fmt (
    .lines_in (io_s2_reg),
    .wlen     (wlen),
    .rd_word  (rd_word)
  );
  logic [1:0] dly_code;
  logic [3:0] dly_units;
  logic       wr_ok;
  assign dly_code = st_reg.comm_options_byte[sco_pkg::DLY_LSB+:2];
  assign dly_units = {1'b0, dly_code, 1'b0};
  assign wr_ok = ({wlen, 1'b0} == cmd_digits) &&
                 (wlen != 4'h0);
  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.go      = 1'b0;
    st_next.syn_err = 1'b0;
    st_next.refused = 1'b0;
    st_next.send    = 1'b0;
    st_next.tick    = 1'b0;
    if (st_reg.tick_div == 7'(sco_pkg::TICK_CYC - 1)) begin
      st_next.tick_div = 7'h00;
      st_next.tick     = 1'b1;
    end else begin
      st_next.tick_div = st_reg.tick_div + 7'h01;
    end
    if (ev_rise) begin
      st_next.ev_cnt = st_reg.ev_cnt + 32'h0000_0001;
    end
    // setup applied after its response, except the baud byte
    if (resp_done && st_reg.pend_valid) begin
      st_next.addr                   = st_reg.pend_setup[31:24];
      st_next.comm_options_byte      = st_reg.pend_setup[15:8];
      st_next.filter_wordlength_byte = st_reg.pend_setup[7:0];
      st_next.pend_valid             = 1'b0;
    end
    // command handling
    if (cmd_valid) begin
      st_next.unlocked = (cmd_code == sco_pkg::SCO_CMD_UNLOCK);
      if (cmd_bitop) begin
        st_next.out_lat[cmd_bitidx] = cmd_bitval;
        st_next.dly_run = 1'b1;
      end else begin
        case (cmd_code)
          sco_pkg::SCO_CMD_SETUP: begin
            if (st_reg.unlocked && cmd_setup[3:0] != 4'h0) begin
              st_next.pend_setup = cmd_setup;
              st_next.pend_valid = 1'b1;
              st_next.dly_run    = 1'b1;
            end else begin
              st_next.refused = 1'b1;
            end
          end
          sco_pkg::SCO_CMD_PWRITE: begin
            if (wr_ok) begin
              st_next.out_lat = cmd_pdata[15:0];
              st_next.dly_run = 1'b1;
            end else begin
              st_next.syn_err = 1'b1;
            end
          end
          default: begin
            st_next.dly_run = 1'b1;
          end
        endcase
      end
      st_next.dly_cnt = 4'h0;
    end
    // response delay in character times
    if (st_reg.dly_run && !cmd_valid) begin
      if (st_reg.dly_cnt >= dly_units) begin
        st_next.go      = 1'b1;
        st_next.dly_run = 1'b0;
      end else if (char_time) begin
        st_next.dly_cnt = st_reg.dly_cnt + 4'h1;
      end
    end
    // continuous mode selection and period
    if (cmode_load) begin
      st_next.cmode   = cmode_sel;
      st_next.per_cnt = 32'h0000_0000;
      st_next.last_io = io_s2_reg;
    end
    if (period_load) begin
      st_next.per_ticks = period_ticks;
    end
    if (!native_proto) begin
      st_next.cmode = sco_pkg::SCO_CM_OFF;
    end
    if (!st_reg.busy && native_proto) begin
      case (st_reg.cmode)
        sco_pkg::SCO_CM_TIMER: begin
          if (st_reg.tick) begin
            if (st_reg.per_cnt + 32'h0000_0001 >= st_reg.per_ticks) begin
              st_next.per_cnt = 32'h0000_0000;
              st_next.send    = 1'b1;
            end else begin
              st_next.per_cnt = st_reg.per_cnt + 32'h0000_0001;
            end
          end
        end
        sco_pkg::SCO_CM_EDGE: begin
          if (ev_rise) begin
            st_next.send = 1'b1;
          end
        end
        sco_pkg::SCO_CM_CHG: begin
          if (io_s2_reg != st_reg.last_io) begin
            st_next.last_io = io_s2_reg;
            st_next.send    = 1'b1;
          end
        end
        default: begin
          st_next.send = 1'b0;
        end
      endcase
    end
    if (st_next.send) begin
      st_next.busy = 1'b1;
    end
    if (cont_done && st_reg.busy) begin
      st_next.busy      = 1'b0;
      st_next.pulse_on  = 1'b1;
      st_next.pulse_cnt = 16'h0000;
    end else if (st_reg.pulse_on && st_reg.tick) begin
      if (st_reg.pulse_cnt + 16'h0001 >= 16'(sco_pkg::PULSE_TICKS)) begin
        st_next.pulse_on = 1'b0;
      end else begin
        st_next.pulse_cnt = st_reg.pulse_cnt + 16'h0001;
      end
    end
  end
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg                        <= '0;
      st_reg.addr                   <= sco_pkg::ADDR_RST;
      st_reg.baud                   <= sco_pkg::BAUD_RST;
      st_reg.comm_options_byte      <= sco_pkg::COMM_OPT_RST;
      st_reg.filter_wordlength_byte <= WLEN_RST;
      st_reg.cmode                  <= sco_pkg::SCO_CM_OFF;
    end else begin
      st_reg <= st_next;
    end
  end
  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign echo_req = rx_char &
                    st_reg.comm_options_byte[sco_pkg::ECHO_BIT];
  assign resp_go          = st_reg.go;
  assign resp_syntax_err  = st_reg.syn_err;
  assign resp_refused     = st_reg.refused;
  assign setup_rd = {st_reg.addr, st_reg.baud, st_reg.comm_options_byte,
                     st_reg.filter_wordlength_byte};
  assign parallel_rd      = rd_word;
  assign io_out           = st_reg.out_lat;
  assign word_count       = wlen;
  assign cont_send        = st_reg.send;
  assign recovery_pin_out = 1'b0;
  assign recovery_pin_oe  = ~st_reg.pulse_on;
  assign event_count      = st_reg.ev_cnt;
endmodule : sco_setup_cont

// ==== pkg/sco_pkg.sv ====
// package for setup options and continuous output block
// assumes one 125 MHz clock; character strobes come from the serial core
package sco_pkg;
  // ------------------------------------------------------------
  // clock and times
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned TICK_US         = 1;
  localparam int unsigned TICK_CYC        = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned FILT_5_MS       = 5;
  localparam int unsigned FILT_20_MS      = 20;
  localparam int unsigned FILT_50_MS      = 50;
  localparam int unsigned FILT_5_TICKS    = FILT_5_MS * 1000 / TICK_US;
  localparam int unsigned FILT_20_TICKS   = FILT_20_MS * 1000 / TICK_US;
  localparam int unsigned FILT_50_TICKS   = FILT_50_MS * 1000 / TICK_US;
  localparam int unsigned PULSE_MS        = 5;
  localparam int unsigned PULSE_TICKS     = PULSE_MS * 1000 / TICK_US;
  localparam int unsigned EV_MAX_KHZ      = 20;
  // ------------------------------------------------------------
  // setup byte fields
  // ------------------------------------------------------------
  localparam int unsigned ECHO_BIT        = 2;
  localparam int unsigned DLY_LSB         = 0;
  localparam int unsigned FILT_LSB        = 4;
  localparam int unsigned WLEN_LSB        = 0;
  localparam logic [7:0]  COMM_OPT_RST    = 8'h01;
  localparam logic [7:0]  ADDR_RST        = 8'h31;
  localparam logic [7:0]  BAUD_RST        = 8'h07;
  localparam logic [3:0]  WLEN_MIN        = 4'h1;
  localparam logic [3:0]  WLEN_MAX        = 4'h8;
  localparam int unsigned PHYS_LINES      = 16;
  localparam int unsigned MAX_BITS        = 64;
  // ------------------------------------------------------------
  // continuous modes and commands
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    SCO_CM_OFF   = 4'h1,
    SCO_CM_TIMER = 4'h2,
    SCO_CM_EDGE  = 4'h4,
    SCO_CM_CHG   = 4'h8
  } sco_cmode_t;
  typedef enum logic [2:0] {
    SCO_CMD_NONE   = 3'h0,
    SCO_CMD_UNLOCK = 3'h1,
    SCO_CMD_SETUP  = 3'h2,
    SCO_CMD_PWRITE = 3'h3,
    SCO_CMD_OTHER  = 3'h4
  } sco_cmd_t;
endpackage : sco_pkg

// ==== pkg/sco_tick_if.sv ====
// interface carrying tick enable and filter settings to the debouncer
// assumes all members sit on the single clk domain
`timescale 1ns/1ps
interface sco_tick_if;
  logic       tick;
  logic [1:0] filt_sel;
  modport src (output tick, output filt_sel);
  modport dst (input tick, input filt_sel);
endinterface : sco_tick_if

// ==== sim/sco_host_model.sv ====
// host side model: paces character times, finishes answers and strings
// assumes clk is the block clock; slow stretches every answer
`timescale 1ns/1ps
module sco_host_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic slow,
  input  wire logic resp_any,
  input  wire logic cont_send,
  output logic      char_time,
  output logic      resp_done,
  output logic      cont_done
);
  logic [3:0] div_reg;
  int         rw;
  int         cw;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      div_reg   <= 4'h0;
      rw        <= 0;
      cw        <= 0;
      char_time <= 1'b0;
      resp_done <= 1'b0;
      cont_done <= 1'b0;
    end else begin
      div_reg   <= div_reg + 4'h1;
      char_time <= (div_reg == 4'hF);
      rw        <= resp_any ? (slow ? 40 : 2) : (rw > 0 ? rw - 1 : 0);
      resp_done <= (rw == 1);
      cw        <= cont_send ? (slow ? 60 : 5) : (cw > 0 ? cw - 1 : 0);
      cont_done <= (cw == 1);
    end
  end
endmodule : sco_host_model

// ==== sim/sco_setup_cont_asserts.sv ====
// assertions for setup options and continuous output control
// assumes binding onto sco_setup_cont; one clock, async reset
`timescale 1ns/1ps
module sco_setup_cont_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        cmd_valid,
  input wire logic [2:0]  cmd_code,
  input wire logic [31:0] cmd_setup,
  input wire logic [4:0]  cmd_digits,
  input wire logic [31:0] setup_rd,
  input wire logic        rx_char,
  input wire logic        native_proto,
  input wire logic        echo_req,
  input wire logic        resp_syntax_err,
  input wire logic        resp_refused,
  input wire logic [63:0] parallel_rd,
  input wire logic [15:0] io_out,
  input wire logic [3:0]  word_count,
  input wire logic        cont_send,
  input wire logic        cont_done,
  input wire logic        recovery_pin_out,
  input wire logic        recovery_pin_oe
);
  // ------------------------------------------------------------
  // command decode helpers
  // ------------------------------------------------------------
  logic pw_bad;
  logic su_cmd;
  logic unl_cmd;
  assign pw_bad  = cmd_valid && cmd_code == sco_pkg::SCO_CMD_PWRITE
                   && cmd_digits != {word_count, 1'b0};
  assign su_cmd  = cmd_valid && cmd_code == sco_pkg::SCO_CMD_SETUP;
  assign unl_cmd = cmd_valid && cmd_code == sco_pkg::SCO_CMD_UNLOCK;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_echo_gated: assert property (
    echo_req == (rx_char && setup_rd[8 + sco_pkg::ECHO_BIT]))
    else $error("echo does not follow echo option");
  a_syntax_next: assert property (pw_bad |=> resp_syntax_err)
    else $error("bad digit count not flagged");
  a_io_hold: assert property (pw_bad |=> $stable(io_out))
    else $error("outputs changed on bad write");
  a_lock_refuse: assert property (!unl_cmd ##1 su_cmd |=> resp_refused)
    else $error("setup accepted without unlock");
  a_zero_refuse: assert property (
    su_cmd && cmd_setup[3:0] == 4'h0 |=> resp_refused)
    else $error("zero word count accepted");
  a_wc_range: assert property (word_count >= 4'h1 && word_count <= 4'h8)
    else $error("word count out of range");
  a_rd_pad: assert property (
    (parallel_rd >> {word_count, 3'b000}) == 64'h0)
    else $error("read data beyond word count");
  a_rd_ones: assert property (
    word_count > 4'h2 |-> parallel_rd[23:16] == 8'hFF)
    else $error("missing lines not read as one");
  a_no_foreign: assert property ((!native_proto)[*3] |-> !cont_send)
    else $error("string sent outside native protocol");
  a_pulse_start: assert property (
    cont_done |-> ##[1:3] !recovery_pin_oe)
    else $error("recovery pulse not started");
  a_pulse_low: assert property (
    $fell(recovery_pin_oe) |-> (!recovery_pin_oe && !recovery_pin_out)[*8])
    else $error("recovery pulse not held low");
  c_cont: cover property (cont_send);
  c_refuse: cover property (resp_refused);
  c_syntax: cover property (resp_syntax_err);
endmodule : sco_setup_cont_chk
bind sco_setup_cont sco_setup_cont_chk u_chk (
  .clk, .rst, .cmd_valid, .cmd_code, .cmd_setup, .cmd_digits, .setup_rd,
  .rx_char,
  .native_proto, .echo_req, .resp_syntax_err, .resp_refused, .parallel_rd,
  .io_out, .word_count, .cont_send, .cont_done, .recovery_pin_out,
  .recovery_pin_oe
);

// ==== sim/tb_setup_options_continuous_output.sv ====
// self-checking bench for sco_setup_cont with host model
// assumes host model paces character times and finishes answers
`timescale 1ns/1ps
module tb_setup_options_continuous_output;
  logic        clk, rst, cmd_valid, cmd_bitop, cmd_bitval, rx_char, slow;
  logic        native_proto, cmode_load, period_load, event_input_pin;
  logic        echo_req, resp_go, resp_syntax_err, resp_refused, resp_done;
  logic        char_time, cont_send, cont_done, recovery_pin_out;
  logic        recovery_pin_oe;
  logic [2:0]  cmd_code;
  logic [3:0]  cmd_bitidx, cmode_sel, word_count;
  logic [4:0]  cmd_digits;
  logic [7:0]  b3, nt;
  logic [15:0] io_pin_in, io_out, o;
  logic [31:0] cmd_setup, period_ticks, setup_rd, event_count, e0;
  logic [63:0] cmd_pdata, parallel_rd, m, p;
  logic [10:0] q[$];
  int          bad_count, num_checks, n, done_n, cont_n, c0;
  sco_setup_cont dut (
    .clk, .rst, .cmd_valid, .cmd_code, .cmd_setup, .cmd_digits, .cmd_pdata,
    .cmd_bitop, .cmd_bitval, .cmd_bitidx, .resp_done, .rx_char, .char_time,
    .native_proto, .cmode_sel, .cmode_load, .period_load, .period_ticks,
    .io_pin_in, .event_input_pin, .echo_req, .resp_go, .resp_syntax_err,
    .resp_refused, .setup_rd, .parallel_rd, .io_out, .word_count,
    .cont_send, .cont_done, .recovery_pin_out, .recovery_pin_oe,
    .event_count
  );
  sco_host_model host (
    .clk, .rst, .slow, .resp_any(resp_go | resp_syntax_err | resp_refused),
    .cont_send, .char_time, .resp_done, .cont_done
  );
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] e, g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc
  task automatic do_reset;
    rst = 1'b1;
    q.delete();
    cyc(2);
    rst = 1'b0;
    cyc(3);
  endtask : do_reset
  task automatic wdone(input int k);
    int n0;
    n0 = done_n;
    for (int i = 0; i < 400 && done_n < n0 + k; i++) @(posedge clk);
    if (done_n < n0 + k) begin
      bad_count++;
      $display("Error resp_done expected %0d seen %0d", k, done_n - n0);
    end
    cyc(1);
  endtask : wdone
  task automatic cmd(input logic [2:0] c, input logic [31:0] s,
                     input logic [63:0] d, input logic [4:0] g);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_setup = s;
    cmd_pdata = d;
    cmd_digits = g;
    cyc(1);
  endtask : cmd
  task automatic su(input logic [31:0] s, input logic [2:0] k, input bit lk);
    q.push_back({k, 8'hFF});
    if (lk)
      cmd(sco_pkg::SCO_CMD_UNLOCK, 0, 0, 0);
    cmd(sco_pkg::SCO_CMD_SETUP, s, 0, 0);
    cmd_valid = 1'b0;
    wdone((lk && k == 3'b001) ? 2 : 1);
  endtask : su
  task automatic pw(input logic [63:0] d, input logic [4:0] g,
                    input logic [10:0] e);
    q.push_back(e);
    cmd(sco_pkg::SCO_CMD_PWRITE, 0, d, g);
    cmd_valid = 1'b0;
    wdone(1);
  endtask : pw
  task automatic cm(input logic [3:0] md);
    cmode_sel = md;
    cmode_load = 1'b1;
    cyc(1);
    cmode_load = 1'b0;
    c0 = cont_n;
  endtask : cm
  // response watcher: oldest note against each answer
  always @(posedge clk) begin
    if (cmd_valid)
      n = 0;
    else if (char_time)
      n++;
    if (resp_done)
      done_n++;
    if (cont_send)
      cont_n++;
    if ((resp_go | resp_syntax_err | resp_refused) && q.size() > 0) begin
      nt = q[0][7:0] == 8'hFF ? 8'hFF : 8'(n);
      chk("resp", q.pop_front(), {resp_go, resp_syntax_err, resp_refused, nt});
    end
  end
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #(8 * 60000);
    bad_count++;
    stop_test();
  end
  initial begin
    {cmd_valid, cmd_bitop, cmd_bitval, rx_char, cmode_load, slow} = '0;
    {period_load, event_input_pin, cmd_code, cmd_bitidx, cmd_digits} = '0;
    {cmd_setup, cmd_pdata, period_ticks, io_pin_in} = '0;
    {bad_count, num_checks, n, done_n, cont_n} = '0;
    cmode_sel = sco_pkg::SCO_CM_OFF;
    native_proto = 1'b1;
    c0 = $urandom(32'h979C95AF);
    do_reset();
    chk("setup", 32'h31070102, setup_rd);
    chk("oe", 1, recovery_pin_oe);
    su(32'h31070103, 3'b001, 0);
    su(32'h31070100, 3'b001, 1);
    chk("wcount", 2, word_count);
    $display("test refusal done");
    e0 = event_count;
    repeat (3) begin
      event_input_pin = 1'b1;
      cyc(3125);
      event_input_pin = 1'b0;
      cyc(3125);
    end
    chk("events", e0 + 3, event_count);
    $display("test event count done");
    for (int i = 0; i < 8; i++) begin
      b3 = {5'($urandom), i[2], i[1:0]};
      su({16'h3107, b3, 8'h02}, 3'b100, 1);
      chk("setup", {16'h3107, b3, 8'h02}, setup_rd);
      rx_char = 1'b1;
      cyc(1);
      chk("echo", i[2], echo_req);
      rx_char = 1'b0;
      for (int j = 0; j < 40 && char_time !== 1'b1; j++) cyc(1);
      cyc(1);
      p = 64'($urandom) & 64'hFFFF;
      pw(p, 5'd4, {3'b100, 8'({i[1:0], 1'b0})});
      chk("io_out", p[15:0], io_out);
    end
    $display("test echo and delay done");
    for (int k = 1; k <= 8; k++) begin
      slow = k[0];
      su({16'h3107, 8'h00, 2'($urandom), 2'b00, 4'(k)}, 3'b100, 1);
      chk("wcount", k, word_count);
      o = io_out;
      pw(64'h0, 5'(2 * k + 1), {3'b010, 8'hFF});
      chk("io_hold", o, io_out);
      m = (64'h1 << 8 * k) - 64'h1;
      p = {$urandom, $urandom} & m;
      pw(p, 5'(2 * k), {3'b100, 8'hFF});
      chk("io_out", p[15:0], io_out);
      io_pin_in = 16'($urandom);
      cyc(4);
      chk("prd", {48'hFFFF_FFFF_FFFF, io_pin_in} & m, parallel_rd);
    end
    su(32'h31070001, 3'b100, 1);
    cmd_bitop = 1'b1;
    cmd_bitval = 1'b1;
    cmd_bitidx = 4'hC;
    cmd(sco_pkg::SCO_CMD_OTHER, 0, 0, 0);
    cmd_valid = 1'b0;
    cmd_bitop = 1'b0;
    wdone(1);
    chk("bit", 1, io_out[12]);
    su(32'h31070012, 3'b100, 1);
    e0 = event_count;
    event_input_pin = 1'b1;
    cyc(100);
    event_input_pin = 1'b0;
    cyc(100);
    chk("filtered", e0, event_count);
    $display("test word length done");
    do_reset();
    cm(sco_pkg::SCO_CM_EDGE);
    event_input_pin = 1'b1;
    cyc(8);
    chk("edge", c0 + 1, cont_n);
    event_input_pin = 1'b0;
    cyc(30);
    chk("fall", c0 + 1, cont_n);
    chk("oe", 0, recovery_pin_oe);
    do_reset();
    cm(sco_pkg::SCO_CM_CHG);
    io_pin_in = ~io_pin_in;
    cyc(8);
    chk("change", c0 + 1, cont_n);
    cyc(10);
    chk("change_once", c0 + 1, cont_n);
    do_reset();
    period_ticks = 32'h2;
    period_load = 1'b1;
    cyc(1);
    period_load = 1'b0;
    cm(sco_pkg::SCO_CM_TIMER);
    cyc(700);
    chk("timer", 1, cont_n - c0 >= 2);
    do_reset();
    native_proto = 1'b0;
    cm(sco_pkg::SCO_CM_EDGE);
    event_input_pin = 1'b1;
    cyc(10);
    chk("foreign", c0, cont_n);
    $display("test continuous done");
    stop_test();
  end
endmodule : tb_setup_options_continuous_output
